// ==== hw/sscsr_pkg.sv ====
package sscsr_pkg;
  // ----------------------------------------------------------------
  // word layout and timing
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam int CORE_CLK_MHZ = 250;
  // link clock half period made by the host, in ns, and in core cycles
  localparam int LINK_HALF_NS = 64;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
  // frame select set-up and hold around the clock burst, in core cycles
  localparam int FRAME_GAP_CYC = LINK_HALF_CYC;
endpackage

// ==== hw/sscsr_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// three-wire link plus open-drain chain return
interface sscsr_link_if;
  logic frame_sel_b;
  logic sclk;
  logic sdata;
  logic chain_out;
  logic chain_oe;
  // open drain: low only while the device drives, pull-up otherwise
  wire chain_line = chain_oe ? 1'b0 : 1'b1;
  modport device (
    input frame_sel_b,
    input sclk,
    input sdata,
    output chain_out,
    output chain_oe
  );
  modport host (
    output frame_sel_b,
    output sclk,
    output sdata,
    input chain_line
  );
endinterface
`default_nettype wire

// ==== hw/sscsr_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - host sends word most significant bit first
// - host changes data on rising clock edge
// - host uses clock idle low, second edge
// - frame select low across whole transfer
// - old contents shift out on rising edges
// - chain output pulls low only
// - chain passes bits through to next device
// - frame select rise updates all switches
// - any switch combination allowed
// - eight bits per chained device
// - keep last eight bits shifted in
// - one closes a switch, zero opens
// - reset clears register and switches
// - ignore clock and data while deselected
module sscsr_device #(
  parameter int WIDTH = sscsr_pkg::WORD_BITS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  sscsr_link_if.device link,
  output logic [WIDTH-1:0] switch_on,
  output logic frame_active
);
  initial begin
    // the shift path slices WIDTH-2, so one bit cannot be served
    if (WIDTH < 2) begin
      $error("WIDTH must be at least two");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sel_sync;
  logic [2:0] clk_sync;
  logic [2:0] dat_sync;
  logic sel_q;
  logic clk_q;
  logic dat_q;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync <= 3'h7;
      clk_sync <= 3'h0;
      dat_sync <= 3'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], link.frame_sel_b};
      clk_sync <= {clk_sync[1:0], link.sclk};
      dat_sync <= {dat_sync[1:0], link.sdata};
    end
  end

  // filtered levels only move when the last two stages agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 1'b1;
      clk_q <= 1'b0;
      dat_q <= 1'b0;
    end else begin
      if (sel_sync[1] == sel_sync[2]) sel_q <= sel_sync[2];
      if (clk_sync[1] == clk_sync[2]) clk_q <= clk_sync[2];
      if (dat_sync[1] == dat_sync[2]) dat_q <= dat_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  wire sel_next = (sel_sync[1] == sel_sync[2]) ? sel_sync[2] : sel_q;
  wire clk_next = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_q;
  wire selected = !sel_q;
  wire clk_fall = selected && clk_q && !clk_next;
  wire clk_rise = selected && !clk_q && clk_next;
  wire sel_rise = !sel_q && sel_next;

  // ----------------------------------------------------------------
  // shift register and switch latch
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] next_shift;
  logic chain_bit;

  assign next_shift = {shift_reg[WIDTH-2:0], dat_q};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= WIDTH'(sscsr_pkg::SWITCH_RESET);
    end else if (clk_fall) begin
      shift_reg <= next_shift;
    end
  end

  // chain bit changes on rising clock
  // msb passes to next device, eight bits late
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chain_bit <= 1'b1;
    end else if (clk_rise) begin
      chain_bit <= shift_reg[WIDTH-1];
    end else if (!selected) begin
      chain_bit <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_on <= WIDTH'(sscsr_pkg::SWITCH_RESET);
    end else if (sel_rise) begin
      switch_on <= shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pull low only, released for a one
  assign link.chain_out = 1'b0;
  assign link.chain_oe = !chain_bit;
  assign frame_active = selected;
endmodule // sscsr_device
`default_nettype wire

// ==== hw/sscsr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sscsr_host #(
  parameter int WIDTH = sscsr_pkg::WORD_BITS,
  parameter int HALF = sscsr_pkg::LINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  sscsr_link_if.host link,
  input wire logic start,
  input wire logic [15:0] num_bits,
  input wire logic [255:0] tx_word,
  output logic busy,
  output logic done,
  output logic [255:0] rx_word
);
  initial begin
    if (HALF < 1 || WIDTH < 1) begin
      $error("bad host parameters");
    end
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LEAD = 4'h2,
    S_SHIFT = 4'h4,
    S_TAIL = 4'h8
  } sscsr_hstate_t;

  sscsr_hstate_t state;
  logic [15:0] div;
  logic [15:0] left;
  logic [255:0] tx_sr;
  logic [2:0] rx_sync;
  wire div_end = (div == 16'(HALF - 1));

  // msb first, clock idle low, data on rise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      div <= 16'h0000;
      left <= 16'h0000;
      tx_sr <= '0;
      rx_word <= '0;
      link.frame_sel_b <= 1'b1;
      link.sclk <= 1'b0;
      link.sdata <= 1'b0;
      done <= 1'b0;
      rx_sync <= 3'h7;
    end else begin
      done <= 1'b0;
      rx_sync <= {rx_sync[1:0], link.chain_line};
      div <= div_end ? 16'h0000 : div + 16'h0001;
      case (state)
        S_IDLE: begin
          div <= 16'h0000;
          if (start && num_bits != 16'h0000) begin
            tx_sr <= tx_word << (16'd256 - num_bits);
            left <= num_bits;
            link.frame_sel_b <= 1'b0;
            state <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (div_end) begin
            link.sclk <= 1'b1;
            link.sdata <= tx_sr[255];
            tx_sr <= tx_sr << 1;
            state <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (div_end) begin
            if (link.sclk) begin
              // device samples on this fall; take chain bit too
              link.sclk <= 1'b0;
              rx_word <= {rx_word[254:0], rx_sync[2]};
              left <= left - 16'h0001;
              if (left == 16'h0001) state <= S_TAIL;
            end else begin
              link.sclk <= 1'b1;
              link.sdata <= tx_sr[255];
              tx_sr <= tx_sr << 1;
            end
          end
        end
        S_TAIL: begin
          if (div_end) begin
            link.frame_sel_b <= 1'b1;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  assign busy = (state != S_IDLE);
endmodule // sscsr_host
`default_nettype wire

// ==== tb/sscsr_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sscsr_sva (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic frame_sel_b,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic chain_out,
  input wire logic chain_oe,
  input wire logic [7:0] switch_on,
  input wire logic frame_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // link quiet in a frame, long enough to cover filter lag
  sequence s_quiet;
    (!frame_sel_b && $stable(sclk))[*8];
  endsequence
  a_chain_steady: assert property (s_quiet |-> $stable(chain_oe))
    else $error("chain moved without clock edge");
  a_chain_idle: assert property (frame_sel_b[*8] |-> !chain_oe)
    else $error("chain driven while deselected");
  a_chain_low_only: assert property (chain_oe |-> !chain_out)
    else $error("chain driven high");
  a_switch_frozen: assert property ((!frame_sel_b)[*8] |-> $stable(switch_on))
    else $error("switches moved mid frame");
  a_switch_at_end: assert property ($changed(switch_on) |-> frame_sel_b)
    else $error("switches moved while selected");
  a_active_on: assert property ($fell(frame_sel_b) |-> ##[1:6] frame_active)
    else $error("frame not seen");
  a_active_off: assert property ($rose(frame_sel_b) |-> ##[1:6] !frame_active)
    else $error("frame end not seen");
  a_sclk_idle: assert property (frame_sel_b |-> !sclk)
    else $error("clock high while idle");
  a_data_held: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at sampling edge");
endmodule // sscsr_sva
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] sw; logic [255:0] rx; logic [255:0] m;} sscsr_note_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic [15:0] num_bits = 16'h0008;
  logic [255:0] tx_word = '0;
  logic busy, done, frame_active;
  logic [255:0] rx_word;
  logic [7:0] switch_on;
  logic [7:0] reg_model = 8'h00;
  sscsr_note_t q[$];
  int lens[8] = '{8, 8, 1, 5, 12, 16, 256, 8};
  int n_errors = 0;
  int checks = 0;
  sscsr_link_if link ();
  sscsr_host i_sscsr_host (.core_clk(core_clk), .rst_b(rst_b), .link(link), .start(start),
    .num_bits(num_bits), .tx_word(tx_word), .busy(busy), .done(done), .rx_word(rx_word));
  sscsr_device i_sscsr_device (.core_clk(core_clk), .rst_b(rst_b), .link(link),
    .switch_on(switch_on), .frame_active(frame_active));
  sscsr_sva i_sscsr_sva (.core_clk(core_clk), .rst_b(rst_b), .frame_sel_b(link.frame_sel_b),
    .sclk(link.sclk), .sdata(link.sdata), .chain_out(link.chain_out),
    .chain_oe(link.chain_oe), .switch_on(switch_on), .frame_active(frame_active));
  // 250 MHz core clock
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one frame of n random bits; old word returns on the chain first
  task automatic frame(input int n);
    logic [263:0] s;
    sscsr_note_t nt;
    int k;
    @(negedge core_clk);
    for (k = 0; k < 8; k++) tx_word[k*32+:32] = $urandom;
    nt.m = (n == 256) ? '1 : ((256'h1 << n) - 256'h1);
    s = ({256'h0, reg_model} << n) | (tx_word & nt.m);
    nt.sw = s[7:0];
    nt.rx = s[263:8] & nt.m;
    reg_model = s[7:0];
    q.push_back(nt);
    num_bits = n[15:0];
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    chk(256'(busy), 256'h1);
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge core_clk);
    if (done !== 1'b1) begin
      n_errors++;
      conclude();
    end
    @(negedge core_clk);
    chk(256'(busy), 256'h0);
    repeat (12) @(negedge core_clk);
  endtask
  // watcher: switches settle a few cycles after select rises
  always @(posedge core_clk) begin
    if (done === 1'b1) begin
      sscsr_note_t nt;
      repeat (8) @(negedge core_clk);
      if (q.size() == 0) chk(256'h1, 256'h0);
      else begin
        nt = q.pop_front();
        // last eight bits kept, any pattern allowed
        chk(256'(switch_on), 256'(nt.sw));
        chk(rx_word & nt.m, nt.rx);
      end
    end
  end
  // main sequence, including a reset in mid run
  initial begin
    void'($urandom(59910));
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    chk(256'(switch_on), 256'h0);
    foreach (lens[i]) frame(lens[i]);
    rst_b = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(256'(switch_on), 256'h0);
    reg_model = 8'h00;
    rst_b = 1'b1;
    frame(8);
    frame(3);
    conclude();
  end
endmodule // tb
`default_nettype wire
